// File: hw/tqc_pkg.sv
// Package of constants for the dual channel torque cutoff interlock.
// Assumes a 50 MHz clock and an AHB-Lite slave with word registers.
// Summary of operation
// - Input A open requests stop, shorted runs.
// - Input B open requests stop, shorted runs.
// - Either channel alone removes gate drive.
// - Both shorted with supply: enable, no failure.
// - Any open input: drive off, failure flagged.
// - Contact levels under 1 ms are ignored; supply flags act at the next edge.
// - A open, B shorted: gate enable deasserted.
// - A shorted, B open: gate power cut.
// - Supply over or under voltage drops gate enable.
// - Self-test runs at every power-on.
// - Self-test fault raises a power-on alarm.
// - Safe state keeps PWM removed, de-energize to trip.
package tqc_pkg;
  // Timing.
  localparam int CLK_HZ = 50000000;
  localparam int HOLD_US = 1000;
  localparam int RESP_US = 8000;
  localparam int HOLD_CYC = (CLK_HZ / 1000000) * HOLD_US;
  localparam int RESP_CYC = (CLK_HZ / 1000000) * RESP_US;
  localparam int FLT_W = 16;
  localparam int SELFTEST_CYC = 16;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_ID = 8'h10;
  // Identification word; the value is arbitrary and names no maker or part.
  localparam logic [31:0] ID_VALUE = 32'h00005A01;
  // Control fields.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR_ERR = 1;
  localparam int CTRL_SELFTEST = 2;
  // Event bits in the interrupt status.
  localparam int EV_TRIP = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_SUPPLY = 2;
  localparam int EV_ALARM = 3;
  localparam int EV_W = 4;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  // Self-test sequencer, Gray coded along its path.
  typedef enum logic [1:0] {
    ST_FORCE = 2'b00,
    ST_CHECK = 2'b01,
    ST_DONE = 2'b11
  } tqc_st_t;
endpackage

// File: hw/tqc_cutoff.sv
// Dual channel torque cutoff interlock with an AHB-Lite register slave.
// Assumes safety inputs and supply flags are synchronous-safe levels sampled here.
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module tqc_cutoff
  import tqc_pkg::*;
(
  // Clock, reset, enable.
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  // Safety contacts, high while shorted to the common.
  input wire logic SAFE_INPUT_A,
  input wire logic SAFE_INPUT_B,
  // Isolated supply monitors, high when out of range.
  input wire logic SUPPLY_OVER_VOLTAGE,
  input wire logic SUPPLY_UNDER_VOLTAGE,
  // Drive requested PWM.
  input wire logic [5:0] PWM_IN,
  // Power stage.
  output logic GATE_ENABLE,
  output logic GATE_POWER,
  output logic [5:0] PWM_OUT,
  output logic CHAN_A_TRUE,
  output logic CHAN_A_INVERTED,
  output logic CHAN_B_TRUE,
  output logic CHAN_B_INVERTED,
  output logic SAFETY_FAILURE,
  output logic SELFTEST_ALARM,
  output logic IRQ,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);

  // Filter a synchronised level: it changes only after a steady 1 ms.
  function automatic logic [FLT_W-1:0] flt_next(input logic raw, input logic cur,
                                                input logic [FLT_W-1:0] cnt);
    if (raw == cur) begin
      flt_next = '0;
    end else begin
      flt_next = cnt + 1'b1;
    end
  endfunction

  logic a_s1_q, a_s2_q, b_s1_q, b_s2_q;
  logic a_flt_q, b_flt_q;
  logic [FLT_W-1:0] a_cnt_q, b_cnt_q;
  logic [FLT_W-1:0] a_cnt_d, b_cnt_d;
  logic fail_q, alarm_q, supply_q;
  logic [31:0] ctrl_q;
  logic [EV_W-1:0] irq_stat_q, irq_mask_q, ev_now;
  logic [5:0] pwm_q;
  logic ge_q, gp_q;
  tqc_st_t st_q;
  logic [4:0] st_cnt_q;
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;

  // Two flops per contact before the filter; the first flop feeds only the second.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      a_s1_q <= 1'b0;
      a_s2_q <= 1'b0;
      b_s1_q <= 1'b0;
      b_s2_q <= 1'b0;
    end else if (CE) begin
      a_s1_q <= SAFE_INPUT_A;
      a_s2_q <= a_s1_q;
      b_s1_q <= SAFE_INPUT_B;
      b_s2_q <= b_s1_q;
    end
  end

  assign a_cnt_d = flt_next(a_s2_q, a_flt_q, a_cnt_q);
  assign b_cnt_d = flt_next(b_s2_q, b_flt_q, b_cnt_q);
  wire a_take = (a_cnt_d >= FLT_W'(HOLD_CYC));
  wire b_take = (b_cnt_d >= FLT_W'(HOLD_CYC));

  // Glitch filters: a level shorter than the hold time never reaches the channel.
  // Filtered levels reset open, so the drive starts in the safe state.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      a_cnt_q <= '0;
      b_cnt_q <= '0;
      a_flt_q <= 1'b0;
      b_flt_q <= 1'b0;
    end else if (CE) begin
      a_cnt_q <= a_take ? '0 : a_cnt_d;
      b_cnt_q <= b_take ? '0 : b_cnt_d;
      if (a_take) begin
        a_flt_q <= a_s2_q;
      end
      if (b_take) begin
        b_flt_q <= b_s2_q;
      end
    end
  end

  // Channel states; open contact means stop. Self-test forces both channels open.
  wire testing = (st_q != ST_DONE);
  wire a_run = a_flt_q & !testing;
  wire b_run = b_flt_q & !testing;
  wire supply_bad = SUPPLY_OVER_VOLTAGE | SUPPLY_UNDER_VOLTAGE;
  wire sw_run = ctrl_q[CTRL_RUN];
  wire clr_err = wr_pend_q && (addr_q == REG_CTRL) && HWDATA[CTRL_CLR_ERR];
  wire start_test = wr_pend_q && (addr_q == REG_CTRL) && HWDATA[CTRL_SELFTEST];
  // Channel A drops the driver enable, channel B the driver power; each alone stops PWM.
  wire ge_d = a_run & b_run & !supply_bad & !alarm_q;
  wire gp_d = b_run & !alarm_q;
  wire fail_set = !testing && !(a_flt_q & b_flt_q);

  // Power stage outputs are registered, so shutoff lands one edge after the filter,
  // far inside the 8 ms budget: sync 2 + filter 1 ms + 1 cycle.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ge_q <= 1'b0;
      gp_q <= 1'b0;
      pwm_q <= '0;
    end else if (CE) begin
      ge_q <= ge_d;
      gp_q <= gp_d;
      pwm_q <= (ge_d & gp_d & sw_run) ? PWM_IN : 6'h00;
    end
  end

  // Failure latch holds until software clears it with both inputs shorted or while the self-test runs; set wins.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      fail_q <= 1'b0;
      supply_q <= 1'b0;
    end else if (CE) begin
      if (fail_set) begin
        fail_q <= 1'b1;
      end else if (clr_err) begin
        fail_q <= 1'b0;
      end
      supply_q <= supply_bad;
    end
  end

  // Power-on self-test: both channels forced open, then the shutoff path must respond.
  // A gate stage that stays on while forced off is a fault and raises the alarm.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_q <= ST_FORCE;
      st_cnt_q <= '0;
      alarm_q <= 1'b0;
    end else if (CE) begin
      unique case (st_q)
        ST_FORCE: begin
          st_cnt_q <= st_cnt_q + 1'b1;
          if (st_cnt_q == 5'(SELFTEST_CYC)) begin
            st_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (ge_q | gp_q | (pwm_q != 6'h00)) begin
            alarm_q <= 1'b1;
          end
          st_q <= ST_DONE;
        end
        ST_DONE: begin
          st_cnt_q <= '0;
          if (start_test) begin
            st_q <= ST_FORCE;
          end else if (clr_err) begin
            alarm_q <= 1'b0;
          end
        end
        default: begin
          st_q <= ST_FORCE;
        end
      endcase
    end
  end

  // Interrupt events.
  assign ev_now[EV_TRIP] = ge_q & !ge_d;
  assign ev_now[EV_FAIL] = fail_set & !fail_q;
  assign ev_now[EV_SUPPLY] = supply_bad & !supply_q;
  assign ev_now[EV_ALARM] = (st_q == ST_CHECK) & (ge_q | gp_q | (pwm_q != 6'h00));

  // AHB-Lite address phase decode.
  wire take = HSEL & HREADY & HTRANS[1];
  wire w1c = wr_pend_q && (addr_q == REG_IRQ_STAT);

  // Bus capture and registers; zero wait states.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      ctrl_q <= CTRL_RST;
      irq_mask_q <= MASK_RST;
      irq_stat_q <= '0;
    end else if (CE) begin
      wr_pend_q <= take & HWRITE;
      rd_pend_q <= take & !HWRITE;
      if (take) begin
        addr_q <= HADDR[7:0];
      end
      if (wr_pend_q && addr_q == REG_CTRL) begin
        ctrl_q <= {31'h00000000, HWDATA[CTRL_RUN]};
      end
      if (wr_pend_q && addr_q == REG_IRQ_MASK) begin
        irq_mask_q <= HWDATA[EV_W-1:0];
      end
      irq_stat_q <= (irq_stat_q & ~(w1c ? HWDATA[EV_W-1:0] : '0)) | ev_now;
    end
  end

  // Read mux; unmapped offsets read zero.
  wire [31:0] status_word = {24'h000000, testing, alarm_q, supply_bad, fail_q,
                             b_flt_q, a_flt_q, gp_q, ge_q};
  wire [31:0] rd_mux = (addr_q == REG_CTRL) ? ctrl_q :
                       (addr_q == REG_STATUS) ? status_word :
                       (addr_q == REG_IRQ_STAT) ? {28'h0000000, irq_stat_q} :
                       (addr_q == REG_IRQ_MASK) ? {28'h0000000, irq_mask_q} :
                       (addr_q == REG_ID) ? ID_VALUE : 32'h00000000;

  assign HRDATA = rd_pend_q ? rd_mux : 32'h00000000;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign GATE_ENABLE = ge_q;
  assign GATE_POWER = gp_q;
  assign PWM_OUT = pwm_q;
  // Complementary channel signals follow the filtered contacts.
  assign CHAN_A_TRUE = a_flt_q;
  assign CHAN_A_INVERTED = !a_flt_q;
  assign CHAN_B_TRUE = b_flt_q;
  assign CHAN_B_INVERTED = !b_flt_q;
  assign SAFETY_FAILURE = fail_q;
  assign SELFTEST_ALARM = alarm_q;
  assign IRQ = |(irq_stat_q & irq_mask_q);
endmodule

// File: testbench/tqc_cutoff_asserts.sv
// Checker for the torque cutoff block, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module tqc_cutoff_asserts
  import tqc_pkg::*;
(
  // Clock and control.
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic SAFE_INPUT_A,
  input wire logic SUPPLY_OVER_VOLTAGE,
  input wire logic SUPPLY_UNDER_VOLTAGE,
  // Power stage.
  input wire logic [5:0] PWM_OUT,
  input wire logic GATE_ENABLE,
  input wire logic GATE_POWER,
  input wire logic CHAN_A_TRUE,
  input wire logic CHAN_A_INVERTED,
  input wire logic CHAN_B_TRUE,
  input wire logic CHAN_B_INVERTED,
  input wire logic SAFETY_FAILURE
);
  int held_q;
  logic last_q;
  // Counts how long contact A stood still, so an early filter move is caught.
  always_ff @(posedge CLK) begin
    last_q <= SAFE_INPUT_A;
    held_q <= (!RST_B || SAFE_INPUT_A != last_q) ? 0 : held_q + 1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // A fall caused by reset itself is not a trip, hence the past reset term.
  sequence s_a_drop;
    CE && $past(RST_B) && $fell(CHAN_A_TRUE);
  endsequence
  a_supply_cut: assert property (CE && (SUPPLY_OVER_VOLTAGE || SUPPLY_UNDER_VOLTAGE)
    |=> !GATE_ENABLE) else $error("gate enable kept in supply fault");
  a_chan_a_cut: assert property (CE && !CHAN_A_TRUE |=> !GATE_ENABLE)
    else $error("gate enable kept with channel A open");
  a_chan_b_cut: assert property (CE && !CHAN_B_TRUE |=> !GATE_ENABLE && !GATE_POWER)
    else $error("gate power kept with channel B open");
  a_chan_pairs: assert property (CHAN_A_TRUE != CHAN_A_INVERTED
    && CHAN_B_TRUE != CHAN_B_INVERTED) else $error("channel pair not complementary");
  a_fail_set: assert property (s_a_drop |=> SAFETY_FAILURE)
    else $error("failure not flagged on open input");
  a_fail_latch: assert property (SAFETY_FAILURE && !CHAN_A_TRUE |=> SAFETY_FAILURE)
    else $error("failure cleared while input open");
  a_pwm_off: assert property (!GATE_ENABLE [*2] |-> PWM_OUT == 6'h00)
    else $error("pwm passed with gate disabled");
  a_filter_hold: assert property ($past(RST_B) && $changed(CHAN_A_TRUE)
    |-> held_q >= HOLD_CYC - 4) else $error("short level change accepted");
endmodule
bind tqc_cutoff tqc_cutoff_asserts u_asserts (.*);

// File: testbench/tqc_relay.sv
// Model of the external safety relay driving the two contacts, bit 0 is A.
// Assumes the bench asks for levels and, on purpose only, for glitches.
`timescale 1ns/1ns
module tqc_relay
  import tqc_pkg::*;
(
  // Requests from the bench, one means shorted.
  input wire logic clk,
  input wire logic [1:0] req,
  input wire logic [1:0] flip,
  // Contacts.
  output logic [1:0] contact
);
  int held_q = 0;
  logic [1:0] lvl_q = 2'b11;
  // A new level is taken only once the old one stood its full hold time.
  always_ff @(posedge clk) begin
    if (req != lvl_q && held_q >= HOLD_CYC) begin
      lvl_q <= req;
      held_q <= 0;
    end else begin
      held_q <= held_q + 1;
    end
  end
  assign contact = lvl_q ^ flip; // Flip breaks the hold on command.
endmodule

// File: testbench/tqc_cutoff_tb_top.sv
// Testbench of the torque cutoff block: bus, trips, supply faults, glitches.
// Assumes the relay model and the bound checker are compiled with it.
`timescale 1ns/1ns
module tqc_cutoff_tb_top;
  import tqc_pkg::*;
  logic clk, rst_b, ce, ov, uv, hw, ge, gp, ca, cai, cb, cbi, fail, alarm, irq, rdy, resp;
  logic [1:0] req, flip, con, htr;
  logic [5:0] pwm, pwo;
  logic [31:0] ha, hwd, hrd, rd;
  int failures, n_checks, cyc, k;
  tqc_relay u_relay (.clk(clk), .req(req), .flip(flip), .contact(con));
  tqc_cutoff uut (.CLK(clk), .RST_B(rst_b), .CE(ce), .SAFE_INPUT_A(con[0]),
    .SAFE_INPUT_B(con[1]), .SUPPLY_OVER_VOLTAGE(ov), .SUPPLY_UNDER_VOLTAGE(uv),
    .PWM_IN(pwm), .GATE_ENABLE(ge), .GATE_POWER(gp), .PWM_OUT(pwo), .CHAN_A_TRUE(ca),
    .CHAN_A_INVERTED(cai), .CHAN_B_TRUE(cb), .CHAN_B_INVERTED(cbi), .SAFETY_FAILURE(fail),
    .SELFTEST_ALARM(alarm), .IRQ(irq), .HSEL(1'b1), .HADDR(ha), .HTRANS(htr), .HWRITE(hw),
    .HSIZE(3'h2), .HWDATA(hwd), .HREADY(rdy), .HRDATA(hrd), .HREADYOUT(rdy), .HRESP(resp));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Expected enable, power and failure from contact levels and supply state.
  function automatic logic [2:0] model(int a, int b, int sup);
    return {1'(a && b && sup == 0), 1'(b), 1'(a == 0 || b == 0)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One AHB-Lite single word transfer; entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    ha <= {24'h00, a};
    hw <= w;
    htr <= 2'b10;
    do @(posedge clk); while (rdy !== 1'b1);
    htr <= 2'b00;
    hwd <= wd;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrd;
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 110000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    {rst_b, ov, uv, hw, flip, htr, pwm, ha, hwd} = '0;
    req = 2'b11;
    ce = 1'b1;
    {failures, n_checks, cyc} = '0;
    void'($urandom(31));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[7], 1'b1);
    chk({resp, rdy}, 2'b01);
    bus(1'b0, REG_ID, 32'h0);
    chk(rd, ID_VALUE);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, REG_IRQ_MASK, 32'h0);
    chk(rd, {28'h0, MASK_RST});
    repeat (30) @(posedge clk);
    chk(alarm, 1'b0);
    for (k = 0; k < 60000 && !(ca && cb); k++) @(posedge clk);
    bus(1'b1, REG_CTRL, 32'h3);
    pwm <= 6'($urandom());
    repeat (4) @(posedge clk);
    chk({ge, gp, fail}, model(1, 1, 0));
    chk(pwo, pwm);
    chk({ca, cai, cb, cbi}, 4'hA);
    // Over voltage drops the enable one edge later, masked event keeps the line quiet.
    ov <= 1'b1;
    repeat (2) @(posedge clk);
    chk(ge, model(1, 1, 1) >> 2);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd[EV_SUPPLY], 1'b1);
    chk(irq, 1'b0);
    bus(1'b1, REG_IRQ_MASK, 32'h4);
    @(posedge clk);
    chk(irq, 1'b1);
    ov <= 1'b0;
    uv <= 1'b1;
    repeat (2) @(posedge clk);
    chk(ge, 1'b0);
    uv <= 1'b0;
    bus(1'b1, REG_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    chk(ge, 1'b1);
    // With the clock enable low all state freezes, so a supply fault cannot move the enable.
    ce <= 1'b0;
    ov <= 1'b1;
    repeat (3) @(posedge clk);
    chk(ge, 1'b1);
    ce <= 1'b1;
    ov <= 1'b0;
    repeat (2) @(posedge clk);
    // Contact A opens while B takes a glitch shorter than the hold time.
    req <= 2'b10;
    flip <= 2'b10;
    repeat (1000) @(posedge clk);
    flip <= 2'b00;
    for (k = 1000; k < 60000 && ge; k++) @(posedge clk);
    chk(k < RESP_CYC, 1'b1);
    repeat (4) @(posedge clk);
    chk({ge, gp, fail}, model(0, 1, 0));
    chk({ca, cb}, 2'b01);
    chk(pwo, 6'h00);
    bus(1'b1, REG_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk(fail, 1'b1);
    test_done;
  end
endmodule
